/* common/swa_defines.vh */
// Constants for the frame sync window acquisition block.
// Assumes a 40 MHz system clock and a 19.2 Hz frame driven by an outside divider.
`ifndef SWA_DEFINES_VH
`define SWA_DEFINES_VH

// ----------------------------------------------------------------------
// Clocking
// ----------------------------------------------------------------------
`define SWA_CLK_NS 25
`define SWA_TICK_NS 200
`define SWA_TICK_DIV (`SWA_TICK_NS / `SWA_CLK_NS)
`define SWA_TICK_PHASE_W 3
`define SWA_TICK_FALL_PHASE 3'h7

// ----------------------------------------------------------------------
// Window and frame timing
// ----------------------------------------------------------------------
`define SWA_WINDOW_NS 25000
`define SWA_WINDOW_TICKS (`SWA_WINDOW_NS / `SWA_TICK_NS)
`define SWA_FRAME_RATE_DHZ 192
`define SWA_TIMEOUT_S 20
`define SWA_FORCE_S 1
`define SWA_TIMEOUT_FRAMES ((`SWA_TIMEOUT_S * `SWA_FRAME_RATE_DHZ) / 10)
`define SWA_FORCE_FRAMES ((`SWA_FORCE_S * `SWA_FRAME_RATE_DHZ) / 10)

// ----------------------------------------------------------------------
// Lock history
// ----------------------------------------------------------------------
`define SWA_HIST_W 8
`define SWA_HIST_RESET 8'hFF

`endif

/* verilog/swa_lock_history.v */
// Lock history shift register: good comparisons shift zeros in from the top,
// bad ones shift ones in from the bottom. Same clock domain as its caller.
`timescale 1ns/1ps
`include "swa_defines.vh"

module swa_lock_history #(
   parameter W = `SWA_HIST_W
) (
   // Clock and reset
   input wire clock,
   input wire rst,
   // Shift requests, one-cycle pulses
   input wire shift_good,
   input wire shift_bad,
   // State
   output reg [W-1:0] hist_r,
   output wire all_ones,
   output wire all_zeros
);

   always @(posedge clock) begin
      if (rst) begin
         hist_r <= {W{1'b1}};
      end else if (shift_good) begin
         hist_r <= {1'b0, hist_r[W-1:1]};
      end else if (shift_bad) begin
         hist_r <= {hist_r[W-2:0], 1'b1};
      end
   end

   assign all_ones = &hist_r;
   assign all_zeros = ~|hist_r;

endmodule // swa_lock_history

/* verilog/swa_sync_window.v */
// Slave frame sync acquisition: windows, samples and compares the detected
// carrier edge with the predicted sync, drives divider resets and receive forcing.
// Assumes frame_pos comes from the divider on this clock, in 5 MHz ticks,
// and that the divider loads SYNC_POS when reset_out pulses.
//
// Contract
// - Accept received rising edge only within 25 us before predicted sync; while acquiring, the code accepts every rising edge.
// - After acceptance, window opens no earlier than 25 us before last edge.
// - Correction per frame limited to 25 us; long pulses take several frames.
// - Latch sampler, comparison and history input sample on 5 MHz falling edge.
// - While acquiring, issue a divider reset pulse each frame, looped back.
// - Good comparison shifts zero in one side, bad shifts one in other.
// - Eight-bit history; eight good declare lock, eight bad declare loss.
// - History all ones: reset pulse on every detected carrier rising edge.
// - After about 20 s out of sync, force receive for about 1 s.
`timescale 1ns/1ps
`include "swa_defines.vh"

module swa_sync_window #(
   parameter FRAME_W = 18,
   parameter [17:0] SYNC_POS = 18'h20000,
   parameter [17:0] FRAME_LEN = 18'h3F940,
   parameter [15:0] TIMEOUT_FRAMES = `SWA_TIMEOUT_FRAMES,
   parameter [15:0] FORCE_FRAMES = `SWA_FORCE_FRAMES
) (
   // Clock and reset
   input wire clock,
   input wire rst,
   // Divider position, 5 MHz ticks into the frame
   input wire [FRAME_W-1:0] frame_pos,
   // Detected carrier pin, asynchronous
   input wire carrier_det,
   // Divider control and status
   output reg reset_out,
   output wire tick_5m,
   output wire window_open,
   output reg locked_r,
   output reg sync_error_r,
   output reg force_receive_r,
   output wire [7:0] lock_history_register
);

   localparam [FRAME_W-1:0] WIN_TICKS = `SWA_WINDOW_TICKS;

   // ------------------------------------------------------------------
   // Pin synchroniser and 5 MHz sampling strobe
   // ------------------------------------------------------------------
   reg car_s1_r;
   reg car_s2_r;
   reg car_s3_r;
   reg [`SWA_TICK_PHASE_W-1:0] phase_r;

   always @(posedge clock) begin
      if (rst) begin
         car_s1_r <= 1'b0;
         car_s2_r <= 1'b0;
         car_s3_r <= 1'b0;
         phase_r <= {`SWA_TICK_PHASE_W{1'b0}};
      end else begin
         car_s1_r <= carrier_det;
         car_s2_r <= car_s1_r;
         car_s3_r <= car_s2_r;
         phase_r <= phase_r + 3'h1;
      end
   end

   // Falling edge of the 5 MHz clock, one cycle in eight
   assign tick_5m = (phase_r == `SWA_TICK_FALL_PHASE);
   // Only the leading edge matters; trailing edge is ignored entirely
   wire car_rise = car_s2_r & ~car_s3_r;

   // ------------------------------------------------------------------
   // Window
   // ------------------------------------------------------------------
   wire hist_ones;
   wire hist_zeros;
   reg [FRAME_W-1:0] target_r;
   wire [FRAME_W-1:0] win_start = target_r - WIN_TICKS;
   wire acquiring = hist_ones & ~locked_r;
   // Wide mode accepts every edge; narrow mode only inside the window
   assign window_open = (frame_pos >= win_start) && (frame_pos < target_r);
   wire accept = car_rise & (window_open | acquiring);

   // ------------------------------------------------------------------
   // Edge latch and three samplers
   // ------------------------------------------------------------------
   reg edge_latch_r;
   reg [FRAME_W-1:0] edge_pos_r;
   reg window_latch_sampler;
   reg comparison_sampler;
   reg cmp_pend_r;
   reg win_prev_r;
   wire cmp_point = tick_5m & (frame_pos == target_r);

   always @(posedge clock) begin
      if (rst) begin
         edge_latch_r <= 1'b0;
         edge_pos_r <= {FRAME_W{1'b0}};
         window_latch_sampler <= 1'b0;
         win_prev_r <= 1'b0;
         comparison_sampler <= 1'b0;
         cmp_pend_r <= 1'b0;
         reset_out <= 1'b0;
      end else begin
         // A new edge wins over the clear when the latch is clear; a new edge is dropped while the latch is set
         if (accept & ~edge_latch_r) begin
            edge_latch_r <= 1'b1;
            edge_pos_r <= frame_pos;
         end else if (cmp_point) begin
            edge_latch_r <= 1'b0;
         end
         reset_out <= 1'b0;
         if (tick_5m) begin
            window_latch_sampler <= edge_latch_r;
            win_prev_r <= window_latch_sampler;
            // Reset each frame while acquiring, one per accepted edge
            if (acquiring && window_latch_sampler && !win_prev_r) begin
               reset_out <= 1'b1;
            end
         end
         if (cmp_point) begin
            comparison_sampler <= window_latch_sampler;
            cmp_pend_r <= 1'b1;
         end else if (tick_5m) begin
            cmp_pend_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Lock history and flags
   // ------------------------------------------------------------------
   wire shift_now = tick_5m & cmp_pend_r;

   swa_lock_history #(
      .W(`SWA_HIST_W)
   ) u_hist (
      .clock(clock),
      .rst(rst),
      .shift_good(shift_now & comparison_sampler),
      .shift_bad(shift_now & ~comparison_sampler),
      .hist_r(lock_history_register),
      .all_ones(hist_ones),
      .all_zeros(hist_zeros)
   );

   always @(posedge clock) begin
      if (rst) begin
         locked_r <= 1'b0;
         sync_error_r <= 1'b1;
         target_r <= SYNC_POS;
      end else begin
         if (hist_zeros) begin
            locked_r <= 1'b1;
            sync_error_r <= 1'b0;
         end else if (hist_ones) begin
            locked_r <= 1'b0;
            sync_error_r <= 1'b1;
         end
         // Track the last accepted edge; window stays inside 25 us of it.
         // Predict two ticks past the edge, so that the window latch sampler
         // has caught the latch before the comparison point reads it.
         if (shift_now & comparison_sampler & ~acquiring) begin
            target_r <= edge_pos_r + {{(FRAME_W-2){1'b0}}, 2'h2};
         end else if (reset_out) begin
            target_r <= SYNC_POS;
         end
      end
   end

   // ------------------------------------------------------------------
   // Receive forcing timeout, counted in frames
   // ------------------------------------------------------------------
   reg [15:0] frame_cnt_r;
   wire frame_tick = tick_5m & (frame_pos == {FRAME_W{1'b0}});

   always @(posedge clock) begin
      if (rst) begin
         frame_cnt_r <= 16'h0000;
         force_receive_r <= 1'b0;
      end else if (!sync_error_r) begin
         frame_cnt_r <= 16'h0000;
         force_receive_r <= 1'b0;
      end else if (frame_tick) begin
         // Cycle repeats: long wait, short forced receive, wait again
         if (!force_receive_r && frame_cnt_r >= TIMEOUT_FRAMES - 16'h0001) begin
            force_receive_r <= 1'b1;
            frame_cnt_r <= 16'h0000;
         end else if (force_receive_r && frame_cnt_r >= FORCE_FRAMES - 16'h0001) begin
            force_receive_r <= 1'b0;
            frame_cnt_r <= 16'h0000;
         end else begin
            frame_cnt_r <= frame_cnt_r + 16'h0001;
         end
      end
   end

endmodule // swa_sync_window

/* verification/swa_sync_window_sva.sv */
// Checker for the sync window block, sees only its ports.
// Assumes one clock domain with a synchronous reset.
`timescale 1ns/1ps
module swa_sync_window_sva #(
   parameter FRAME_W = 18
) (
   // Clock, reset and inputs
   input wire clock,
   input wire rst,
   input wire [FRAME_W-1:0] frame_pos,
   input wire carrier_det,
   // Outputs
   input wire reset_out,
   input wire tick_5m,
   input wire window_open,
   input wire locked_r,
   input wire sync_error_r,
   input wire force_receive_r,
   input wire [7:0] lock_history_register
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire [7:0] h = lock_history_register;
   // ------
   // Checks
   // ------
   tick_rate_a: assert property (tick_5m |=> !tick_5m [*7] ##1 tick_5m)
      else $error("tick spacing");
   pulse_one_a: assert property (reset_out |=> !reset_out)
      else $error("reset pulse too long");
   reset_tick_a: assert property (reset_out |-> $past(tick_5m) && $past(h) == 8'hFF)
      else $error("reset off tick or not acquiring");
   hist_shift_a: assert property ($changed(h) && !$past(rst) |-> $past(tick_5m) &&
      (h == {1'b0, $past(h[7:1])} || h == {$past(h[6:0]), 1'b1})) else $error("history step");
   lock_set_a: assert property (h == 8'h00 |-> ##[0:1] locked_r)
      else $error("lock not declared");
   err_set_a: assert property (h == 8'hFF |-> ##[0:1] sync_error_r)
      else $error("error not raised");
   err_clr_a: assert property (h == 8'h00 |-> ##[0:1] !sync_error_r)
      else $error("error not cleared");
   quiet_lock_a: assert property (locked_r && $past(locked_r) |-> !reset_out)
      else $error("reset while locked");
   force_err_a: assert property ($rose(force_receive_r) |-> sync_error_r)
      else $error("force without error");
   cover property ($rose(locked_r));
   cover property ($rose(force_receive_r));
   cover property (reset_out);
endmodule // swa_sync_window_sva

bind swa_sync_window swa_sync_window_sva #(.FRAME_W(FRAME_W)) chk (.clock(clock), .rst(rst),
   .frame_pos(frame_pos), .carrier_det(carrier_det), .reset_out(reset_out), .tick_5m(tick_5m),
   .window_open(window_open), .locked_r(locked_r), .sync_error_r(sync_error_r),
   .force_receive_r(force_receive_r), .lock_history_register(lock_history_register));

/* verification/swa_carrier_model.sv */
// Carrier receiver model: detected sync pulses once per period.
// Assumes the bench clock; spike adds stray pulses on request.
`timescale 1ns/1ps
module swa_carrier_model #(
   parameter PERIOD = 1600,
   parameter WIDTH = 400
) (
   // Clock and control
   input wire clock,
   input wire en,
   input wire spike,
   // Detected carrier
   output reg carrier_det
);
   integer cnt = 0;
   initial carrier_det = 1'b0;
   // Leading edge at a fixed clock phase, clear of the tick
   always @(posedge clock) begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      carrier_det <= (en && cnt < WIDTH) || spike;
   end
endmodule // swa_carrier_model

/* verification/test_sync_window_acquisition.sv */
// Bench for the sync window block with a divider stand-in.
// Assumes the carrier period equals one divider frame.
`timescale 1ns/1ps
module test_sync_window_acquisition;
   localparam F = 200;
   localparam FC = F * 8;
   localparam [17:0] SP = 18'h00096;
   reg clock = 1'b0;
   reg rst = 1'b1;
   reg en = 1'b0;
   reg spike = 1'b0;
   reg [17:0] frame_pos = 18'h00000;
   wire carrier_det, reset_out, tick_5m, locked_r, sync_error_r, force_receive_r;
   wire [7:0] hist;
   wire win;
   integer bad_count = 0;
   integer compares = 0;
   integer n;
   integer resets;
   always #12.5 clock = ~clock;
   swa_sync_window #(.SYNC_POS(SP), .TIMEOUT_FRAMES(16'h0004), .FORCE_FRAMES(16'h0002)) dut (
      .clock(clock), .rst(rst), .frame_pos(frame_pos), .carrier_det(carrier_det),
      .reset_out(reset_out), .tick_5m(tick_5m), .window_open(win), .locked_r(locked_r),
      .sync_error_r(sync_error_r), .force_receive_r(force_receive_r), .lock_history_register(hist));
   swa_carrier_model #(.PERIOD(FC), .WIDTH(400)) rx (.clock(clock), .en(en), .spike(spike),
      .carrier_det(carrier_det));
   // Divider stand-in, reloaded by each reset pulse
   always @(posedge clock)
      if (rst) frame_pos <= 18'h00000;
      else if (reset_out) frame_pos <= SP;
      else if (tick_5m) frame_pos <= (frame_pos == F - 1) ? 18'h00000 : frame_pos + 18'h00001;
   // ---------
   // Utilities
   // ---------
   task chk(input [7:0] got, input [7:0] exp);
      begin
         @(negedge clock);
         compares = compares + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task end_sim;
      begin
         $display("mismatches %0d compares %0d", bad_count, compares);
         if (bad_count == 0 && compares > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   function flag(input integer k);
      flag = (k == 0) ? locked_r : (k == 1) ? sync_error_r : force_receive_r;
   endfunction
   // Bounded wait, frames at most; a timeout ends the run
   task wait_flag(input integer k, input integer frames);
      begin
         n = 0;
         while (flag(k) !== 1'b1 && n < frames * FC) begin
            @(posedge clock);
            n = n + 1;
         end
         if (n >= frames * FC) begin
            chk({7'h00, flag(k)}, 8'h01);
            end_sim;
         end
      end
   endtask
   // Counts reset pulses over some frames, spiking where asked
   task watch(input integer frames, input [17:0] at);
      begin
         resets = 0;
         repeat (frames * FC) begin
            @(posedge clock);
            spike <= (frame_pos === at);
            resets = resets + reset_out;
         end
      end
   endtask
   // ---------
   // Scenarios
   // ---------
   task t_acquire;
      begin
         @(posedge clock);
         en <= 1'b1;
         watch(3, 18'h3FFFF);
         chk({7'h00, resets != 0}, 8'h01);
         wait_flag(0, 14);
         chk(hist, 8'h00);
         chk({7'h00, sync_error_r}, 8'h00);
      end
   endtask
   task t_spike;
      begin
         watch(3, 18'h0000A);
         chk(hist, 8'h00);
         chk(resets[7:0], 8'h00);
      end
   endtask
   // Window closed far from the predicted sync, open just before it
   task t_window(input [17:0] at, input [7:0] exp);
      begin
         n = 0;
         while (frame_pos !== at && n < FC) begin
            @(posedge clock);
            n = n + 1;
         end
         chk({7'h00, win}, exp);
      end
   endtask
   task t_lose;
      begin
         @(posedge clock);
         en <= 1'b0;
         wait_flag(1, 12);
         chk(hist, 8'hFF);
         chk({7'h00, locked_r}, 8'h00);
         wait_flag(2, 8);
         chk({7'h00, force_receive_r}, 8'h01);
      end
   endtask
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      chk(hist, 8'hFF);
      chk({5'h00, locked_r, sync_error_r, force_receive_r}, 8'h02);
      t_acquire;
      t_spike;
      t_window(18'h0000A, 8'h00);
      t_window(18'h0008C, 8'h01);
      t_lose;
      t_acquire;
      end_sim;
   end
endmodule // test_sync_window_acquisition
